// file: verilog/desl_top.sv
// Display event and status logic: port A plug detect, error flags, render response message.
// Assumes all inputs synchronous to i_clk_sys; plug pin sampled directly.
// Function
// - Input-enable bit gates plug pin buffer
// - Enabled buffer lets status follow pin
// - Duration field picks short pulse limit
// - Long sets bit 1, short bit 0
// - Plug status sticky, write-one clears
// - OR of plug status to live status
// - Error bits sticky W1C, OR combined
// - Poison message sets bit 31
// - Table notices set bits 29, 28
// - Plane faults set bits 15 to 23
// - Pipe underrun sets bits 0, 3, 6
// - Pipe A flips and blanks to bits
// - Pipe B events to bits 8 to 13
// - Pipe C events to bits 14 to 22
// - Scanline event at matching compare line
// - Pipe A scanline event in bit 0
// - Only unmasked events send and report
`timescale 1ns/1ns
`default_nettype none
module desl_top
   import desl_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic [19:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [31:0] i_reg_wdata,
   output logic [31:0] o_reg_rdata,
   input wire logic i_plug_detect_pin,
   input wire logic i_poison_msg,
   input wire logic i_graphics_translation_table_invalid,
   input wire logic i_pte_invalid,
   input wire logic [8:0] i_plane_fault,
   input wire logic [2:0] i_fifo_underrun,
   input wire logic [2:0] i_flip_pri_done,
   input wire logic [2:0] i_flip_spr_done,
   input wire logic [2:0] i_vblank_start,
   input wire logic [2:0] i_hblank_start,
   input wire logic [2:0] i_line_start,
   input wire logic [35:0] i_line_count,
   input wire logic [35:0] i_line_compare,
   output logic o_live_plug,
   output logic o_live_error,
   output logic o_resp_valid,
   output logic [31:0] o_resp_msg
);
   import desl_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Register decode
   function automatic logic hit(input logic [19:0] a, input logic [19:0] r);
      return a == r;
   endfunction : hit

   logic wr_plug, wr_err, wr_mask;
   assign wr_plug = i_reg_wr && hit(i_reg_addr, ADDR_PLUG_CTL);
   assign wr_err = i_reg_wr && hit(i_reg_addr, ADDR_ERR_FLAGS);
   assign wr_mask = i_reg_wr && hit(i_reg_addr, ADDR_RESP_MASK);

   ////////////////////////////////////////////////////////////////////////
   // Plug detect control and pulse measurement
   logic plug_en, next_plug_en;
   logic [1:0] plug_dur, next_plug_dur;
   logic [1:0] plug_stat, next_plug_stat;
   desl_pin_state_t pin_st, next_pin_st;
   logic [CNT_W-1:0] pulse_cnt, next_pulse_cnt;
   logic [CNT_W-1:0] short_lim;
   logic pin_gated;
   logic next_live_plug;

   assign pin_gated = plug_en & i_plug_detect_pin;

   always_comb begin
      case (plug_dur)
         2'b00: short_lim = CNT_W'(CYC_DUR_0);
         2'b01: short_lim = CNT_W'(CYC_DUR_1);
         2'b10: short_lim = CNT_W'(CYC_DUR_2);
         default: short_lim = CNT_W'(CYC_DUR_3);
      endcase
   end

   always_comb begin
      logic ev_long;
      logic ev_short;
      ev_long = 1'b0;
      ev_short = 1'b0;
      next_plug_en = plug_en;
      next_plug_dur = plug_dur;
      next_pin_st = pin_st;
      next_pulse_cnt = pulse_cnt;
      case (pin_st)
         DESL_PIN_IDLE: begin
            next_pulse_cnt = '0;
            if (pin_gated) begin
               next_pin_st = DESL_PIN_HIGH;
            end
         end
         DESL_PIN_HIGH: begin
            if (!pin_gated) begin
               next_pin_st = DESL_PIN_IDLE;
               if (pulse_cnt < short_lim) begin
                  ev_short = 1'b1;
               end
            end else if (pulse_cnt == short_lim) begin
               ev_long = 1'b1;
               next_pulse_cnt = pulse_cnt + CNT_W'(1);
            end else if (pulse_cnt < short_lim) begin
               next_pulse_cnt = pulse_cnt + CNT_W'(1);
            end
         end
         default: begin
            next_pin_st = DESL_PIN_IDLE;
         end
      endcase
      next_plug_stat = plug_stat;
      if (wr_plug) begin
         next_plug_en = i_reg_wdata[PLUG_EN_BIT];
         next_plug_dur = i_reg_wdata[PLUG_DUR_LSB +: 2];
         next_plug_stat = plug_stat & ~i_reg_wdata[PLUG_SHORT_BIT +: 2];
      end
      next_plug_stat[PLUG_LONG_BIT] = next_plug_stat[PLUG_LONG_BIT] | ev_long;
      next_plug_stat[PLUG_SHORT_BIT] = next_plug_stat[PLUG_SHORT_BIT] | ev_short;
      next_live_plug = |next_plug_stat;
   end

   ////////////////////////////////////////////////////////////////////////
   // Error flags
   logic [31:0] err, next_err, err_set;
   logic next_live_error;
   always_comb begin
      err_set = RESET_ZERO;
      err_set[ERR_POISON_BIT] = i_poison_msg;
      err_set[ERR_XLAT_TABLE_BIT] = i_graphics_translation_table_invalid;
      err_set[ERR_PTE_BIT] = i_pte_invalid;
      err_set[ERR_FAULT_LSB +: 9] = i_plane_fault;
      for (int p = 0; p < 3; p++) begin
         err_set[p * ERR_UNDER_STRIDE] = i_fifo_underrun[p];
      end
      next_err = err;
      if (wr_err) begin
         next_err = err & ~i_reg_wdata;
      end
      next_err = (next_err | err_set) & ERR_MASK;
      next_live_error = |next_err;
   end

   ////////////////////////////////////////////////////////////////////////
   // Render response message
   logic [31:0] resp_mask, next_resp_mask;
   logic [31:0] ev_raw, ev_gated;
   logic [2:0] line_hit;
   logic next_resp_valid;
   localparam int SL_POS [3] = '{MSG_A_SL, MSG_B_SL, MSG_C_SL};
   localparam int PRI_POS [3] = '{MSG_A_PRI, MSG_B_PRI, MSG_C_PRI};
   localparam int SPR_POS [3] = '{MSG_A_SPR, MSG_B_SPR, MSG_C_SPR};
   localparam int VB_POS [3] = '{MSG_A_VB, MSG_B_VB, MSG_C_VB};
   localparam int HB_POS [3] = '{MSG_A_HB, MSG_B_HB, MSG_C_HB};

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_line
         assign line_hit[g] = i_line_start[g] &&
            (i_line_count[g*12 +: 12] == i_line_compare[g*12 +: 12]);
      end
   endgenerate

   always_comb begin
      ev_raw = RESET_ZERO;
      for (int p = 0; p < 3; p++) begin
         ev_raw[SL_POS[p]] = line_hit[p];
         ev_raw[PRI_POS[p]] = i_flip_pri_done[p];
         ev_raw[SPR_POS[p]] = i_flip_spr_done[p];
         ev_raw[VB_POS[p]] = i_vblank_start[p];
         ev_raw[HB_POS[p]] = i_hblank_start[p];
      end
      ev_gated = ev_raw & ~resp_mask & RESP_MASK_VALID;
      next_resp_mask = wr_mask ? i_reg_wdata : resp_mask;
      next_resp_valid = |ev_gated;
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux
   logic [31:0] next_rdata;
   always_comb begin
      next_rdata = RESET_ZERO;
      if (i_reg_rd) begin
         if (hit(i_reg_addr, ADDR_PLUG_CTL)) begin
            next_rdata[PLUG_EN_BIT] = plug_en;
            next_rdata[PLUG_DUR_LSB +: 2] = plug_dur;
            next_rdata[PLUG_SHORT_BIT +: 2] = plug_stat;
         end else if (hit(i_reg_addr, ADDR_ERR_FLAGS)) begin
            next_rdata = err;
         end else if (hit(i_reg_addr, ADDR_RESP_MASK)) begin
            next_rdata = resp_mask;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State registers, one process per group
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         plug_en <= 1'b0;
         plug_dur <= 2'b00;
         plug_stat <= 2'b00;
         pin_st <= DESL_PIN_IDLE;
         pulse_cnt <= '0;
         o_live_plug <= 1'b0;
      end else begin
         plug_en <= next_plug_en;
         plug_dur <= next_plug_dur;
         plug_stat <= next_plug_stat;
         pin_st <= next_pin_st;
         pulse_cnt <= next_pulse_cnt;
         o_live_plug <= next_live_plug;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         err <= RESET_ZERO;
         o_live_error <= 1'b0;
      end else begin
         err <= next_err;
         o_live_error <= next_live_error;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         resp_mask <= RESET_ZERO;
         o_resp_valid <= 1'b0;
         o_resp_msg <= RESET_ZERO;
      end else begin
         resp_mask <= next_resp_mask;
         o_resp_valid <= next_resp_valid;
         o_resp_msg <= ev_gated;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_reg_rdata <= RESET_ZERO;
      end else begin
         o_reg_rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_buffer_gated: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      !plug_en |=> pin_st == DESL_PIN_IDLE)
      else $error("plug state not idle while buffer disabled");
   a_short_sets: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (pin_st == DESL_PIN_HIGH && !pin_gated && pulse_cnt < short_lim) |=> plug_stat[PLUG_SHORT_BIT])
      else $error("short pulse not recorded");
   a_long_sets: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (pin_st == DESL_PIN_HIGH && pin_gated && pulse_cnt == short_lim) |=> plug_stat[PLUG_LONG_BIT])
      else $error("long pulse not recorded");
   a_plug_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (plug_stat[PLUG_SHORT_BIT] && !(wr_plug && i_reg_wdata[PLUG_SHORT_BIT])) |=> plug_stat[PLUG_SHORT_BIT])
      else $error("plug status dropped without clear");
   a_plug_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (wr_plug && i_reg_wdata[PLUG_SHORT_BIT] && !(pin_st == DESL_PIN_HIGH && !pin_gated)) |=> !plug_stat[PLUG_SHORT_BIT])
      else $error("plug status not cleared by write of one");
   a_plug_live: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      ##1 o_live_plug == |plug_stat)
      else $error("plug live bit differs from status");
   a_err_live: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      ##1 o_live_error == |err)
      else $error("error live bit differs from flags");
   a_err_sticky: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (err[ERR_POISON_BIT] && !(wr_err && i_reg_wdata[ERR_POISON_BIT])) |=> err[ERR_POISON_BIT])
      else $error("error flag dropped without clear");
   a_poison_sets: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      i_poison_msg |=> err[ERR_POISON_BIT])
      else $error("poison event lost");
   a_pte_sets: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      i_pte_invalid |=> err[ERR_PTE_BIT])
      else $error("page table entry event lost");
   a_fault_sets: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      i_plane_fault[8] |=> err[ERR_FAULT_LSB + 8])
      else $error("pipe C sprite fault lost");
   a_underrun_sets: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      i_fifo_underrun[1] |=> err[ERR_UNDER_STRIDE])
      else $error("pipe B underrun lost");
   a_vblank_msg: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (i_vblank_start[0] && !resp_mask[MSG_A_VB]) |=> (o_resp_valid && o_resp_msg[MSG_A_VB]))
      else $error("pipe A vertical blank not sent");
   a_line_msg: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (i_line_start[1] && i_line_count[23:12] == i_line_compare[23:12] && !resp_mask[MSG_B_SL])
      |=> o_resp_msg[MSG_B_SL])
      else $error("pipe B scanline not sent");
   a_reserved_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (err & ~ERR_MASK) == RESET_ZERO)
      else $error("reserved error bit set");
   a_mask_blocks: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      (o_resp_msg & $past(resp_mask)) == RESET_ZERO)
      else $error("masked event reported");
   c_short_pulse: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      $rose(plug_stat[PLUG_SHORT_BIT]));
   c_long_pulse: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      $rose(plug_stat[PLUG_LONG_BIT]));
   c_set_clear: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      wr_err && i_reg_wdata[ERR_POISON_BIT] && i_poison_msg);
   c_resp_sent: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      o_resp_valid && o_resp_msg[MSG_B_SL]);
   c_masked_sent: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
      o_resp_valid && resp_mask != RESET_ZERO);
endmodule : desl_top
`default_nettype wire

// file: verilog/desl_pkg.sv
// Package for the display event and status logic: register map, field layout, timing.
// Assumes a 125 MHz display clock.
package desl_pkg;
   localparam int unsigned CLK_MHZ = 125;
   localparam logic [19:0] ADDR_PLUG_CTL = 20'h44030;
   localparam logic [19:0] ADDR_ERR_FLAGS = 20'h44040;
   localparam logic [19:0] ADDR_RESP_MASK = 20'h44050;
   localparam int PLUG_EN_BIT = 4;
   localparam int PLUG_DUR_LSB = 2;
   localparam int PLUG_LONG_BIT = 1;
   localparam int PLUG_SHORT_BIT = 0;
   localparam int ERR_POISON_BIT = 31;
   localparam int ERR_XLAT_TABLE_BIT = 29;
   localparam int ERR_PTE_BIT = 28;
   localparam int ERR_FAULT_LSB = 15;
   localparam int ERR_UNDER_STRIDE = 3;
   localparam logic [31:0] ERR_MASK = 32'hB0FF_8049;
   localparam logic [31:0] RESP_MASK_VALID = 32'h0070_EF2F;
   localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
   // Short-pulse limits in microseconds
   localparam int unsigned DUR_US_0 = 2000;
   localparam int unsigned DUR_US_1 = 4500;
   localparam int unsigned DUR_US_2 = 6000;
   localparam int unsigned DUR_US_3 = 100000;
   localparam int unsigned CYC_DUR_0 = DUR_US_0 * CLK_MHZ;
   localparam int unsigned CYC_DUR_1 = DUR_US_1 * CLK_MHZ;
   localparam int unsigned CYC_DUR_2 = DUR_US_2 * CLK_MHZ;
   localparam int unsigned CYC_DUR_3 = DUR_US_3 * CLK_MHZ;
   localparam int CNT_W = 24;
   // Per-pipe message bit positions: scanline, primary, sprite, vblank, hblank
   localparam int MSG_A_SL = 0;
   localparam int MSG_A_PRI = 1;
   localparam int MSG_A_SPR = 2;
   localparam int MSG_A_VB = 3;
   localparam int MSG_A_HB = 5;
   localparam int MSG_B_SL = 8;
   localparam int MSG_B_PRI = 9;
   localparam int MSG_B_SPR = 10;
   localparam int MSG_B_VB = 11;
   localparam int MSG_B_HB = 13;
   localparam int MSG_C_SL = 14;
   localparam int MSG_C_PRI = 15;
   localparam int MSG_C_SPR = 20;
   localparam int MSG_C_VB = 21;
   localparam int MSG_C_HB = 22;
   typedef enum logic [1:0] {
      DESL_PIN_IDLE = 2'b00,
      DESL_PIN_HIGH = 2'b01
   } desl_pin_state_t;
endpackage : desl_pkg

// file: testbench/desl_resp_sink.sv
// Render response sink: stands in for the command streamer receiving messages.
// Assumes messages arrive as one-cycle valid pulses on the display clock.
`timescale 1ns/1ns
`default_nettype none
module desl_resp_sink (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic i_resp_valid,
   input wire logic [31:0] i_resp_msg,
   output logic [31:0] o_last_msg,
   output logic [7:0] o_msg_cnt
);
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_last_msg <= 32'h0000_0000;
         o_msg_cnt <= 8'h00;
      end else if (i_resp_valid) begin
         o_last_msg <= i_resp_msg;
         o_msg_cnt <= o_msg_cnt + 8'h01;
      end
   end
endmodule : desl_resp_sink
`default_nettype wire

// file: testbench/desl_top_test.sv
// Self-checking bench for the display event and status logic.
// Assumes the register map and bit layout of desl_pkg.
`timescale 1ns/1ns
`default_nettype none
module desl_top_test;
   import desl_pkg::*;
   logic i_clk_sys, i_rst_b, i_reg_wr, i_reg_rd, pin, o_live_plug, o_live_error, o_resp_valid;
   logic [19:0] i_reg_addr;
   logic [31:0] i_reg_wdata, o_reg_rdata, o_resp_msg, last_msg;
   logic [14:0] ev;
   logic [11:0] rv;
   logic [2:0] ls;
   logic [35:0] lcnt, lcmp;
   logic [7:0] msg_cnt;
   int error_cnt = 0;
   int checks_done = 0;
   int epos[15] = '{0, 3, 6, 15, 16, 17, 18, 19, 20, 21, 22, 23, 28, 29, 31};
   int rpos[12] = '{1, 9, 15, 2, 10, 20, 3, 11, 21, 5, 13, 22};
   int spos[3] = '{0, 8, 14};
   desl_top dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_plug_detect_pin(pin),
      .i_poison_msg(ev[14]), .i_graphics_translation_table_invalid(ev[13]), .i_pte_invalid(ev[12]),
      .i_plane_fault(ev[11:3]), .i_fifo_underrun(ev[2:0]), .i_flip_pri_done(rv[2:0]), .i_flip_spr_done(rv[5:3]),
      .i_vblank_start(rv[8:6]), .i_hblank_start(rv[11:9]), .i_line_start(ls), .i_line_count(lcnt),
      .i_line_compare(lcmp), .o_live_plug(o_live_plug), .o_live_error(o_live_error),
      .o_resp_valid(o_resp_valid), .o_resp_msg(o_resp_msg));
   desl_resp_sink sink (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_resp_valid(o_resp_valid),
      .i_resp_msg(o_resp_msg), .o_last_msg(last_msg), .o_msg_cnt(msg_cnt));
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask : tick
   task automatic wr(input logic [19:0] a, input logic [31:0] d);
      i_reg_addr = a;
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      tick(1);
      i_reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [19:0] a, input logic [31:0] exp, input string what);
      i_reg_addr = a;
      i_reg_rd = 1'b1;
      tick(1);
      i_reg_rd = 1'b0;
      chk(o_reg_rdata, exp, what);
   endtask : rd
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////
   initial begin
      i_clk_sys = 1'b0;
      forever #4 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      #40000;
      error_cnt++;
      $display("[ERR] %0t watchdog expired", $time);
      give_verdict();
   end
   initial begin
      {i_rst_b, i_reg_wr, i_reg_rd, pin, i_reg_addr, i_reg_wdata} = 56'h0;
      {ev, rv, ls, lcnt} = 66'h0;
      lcmp = 36'h003_002_001;
      tick(3);
      i_rst_b = 1'b1;
      chk({29'h0, o_live_plug, o_live_error, o_resp_valid}, 32'h0000_0000, "outputs at reset");
      chk(o_resp_msg | o_reg_rdata, 32'h0000_0000, "data at reset");
      rd(ADDR_ERR_FLAGS, 32'h0000_0000, "err reset");
      wr(ADDR_ERR_FLAGS, 32'hFFFF_FFFF);
      rd(ADDR_ERR_FLAGS, 32'h0000_0000, "err reserved");
      wr(20'h44060, 32'hFFFF_FFFF);
      rd(20'h44060, 32'h0000_0000, "unmapped");
      wr(ADDR_PLUG_CTL, 32'hFFFF_FFE0);
      rd(ADDR_PLUG_CTL, 32'h0000_0000, "plug reserved");
      $display("test reset done");
      for (int i = 0; i < 15; i++) begin
         ev = 15'h0001 << i;
         tick(1);
         ev = 15'h0000;
         chk({31'h0, o_live_error}, 32'h0000_0001, "live err");
         rd(ADDR_ERR_FLAGS, 32'h0000_0001 << epos[i], "err set");
         wr(ADDR_ERR_FLAGS, 32'hFFFF_FFFF);
         rd(ADDR_ERR_FLAGS, 32'h0000_0000, "err clear");
      end
      ev = 15'h4000;
      wr(ADDR_ERR_FLAGS, 32'h8000_0000);
      ev = 15'h0000;
      rd(ADDR_ERR_FLAGS, 32'h8000_0000, "set beats clear");
      wr(ADDR_ERR_FLAGS, 32'h8000_0000);
      chk({31'h0, o_live_error}, 32'h0000_0000, "live err off");
      ev = 15'h0001;
      tick(1);
      ev = 15'h0000;
      i_rst_b = 1'b0;
      tick(1);
      i_rst_b = 1'b1;
      chk({31'h0, o_live_error}, 32'h0000_0000, "live err after reset");
      rd(ADDR_ERR_FLAGS, 32'h0000_0000, "err after reset");
      $display("test errors done");
      pin = 1'b1;
      tick(50);
      pin = 1'b0;
      tick(3);
      rd(ADDR_PLUG_CTL, 32'h0000_0000, "buffer off");
      for (int d = 0; d < 4; d++) begin
         wr(ADDR_PLUG_CTL, 32'h0000_0010 | (d << 2));
         pin = 1'b1;
         tick(50);
         pin = 1'b0;
         tick(3);
         chk({31'h0, o_live_plug}, 32'h0000_0001, "live plug");
         rd(ADDR_PLUG_CTL, 32'h0000_0011 | (d << 2), "short pulse");
         wr(ADDR_PLUG_CTL, 32'h0000_0011 | (d << 2));
         rd(ADDR_PLUG_CTL, 32'h0000_0010 | (d << 2), "plug clear");
         chk({31'h0, o_live_plug}, 32'h0000_0000, "live plug off");
      end
      $display("test plug done");
      wr(ADDR_RESP_MASK, 32'h0000_0000);
      for (int i = 0; i < 12; i++) begin
         rv = 12'h001 << i;
         tick(1);
         rv = 12'h000;
         chk({31'h0, o_resp_valid}, 32'h0000_0001, "resp valid");
         chk(o_resp_msg, 32'h0000_0001 << rpos[i], "resp bit");
      end
      lcnt = 36'h003_002_001;
      for (int p = 0; p < 3; p++) begin
         ls = 3'h1 << p;
         tick(1);
         ls = 3'h0;
         chk(o_resp_msg, 32'h0000_0001 << spos[p], "scanline");
      end
      lcnt = 36'h000_000_000;
      ls = 3'h7;
      tick(1);
      ls = 3'h0;
      chk({31'h0, o_resp_valid}, 32'h0000_0000, "no line match");
      lcmp = 36'h000_000_000;
      ls = 3'h2;
      tick(1);
      ls = 3'h0;
      chk(o_resp_msg, 32'h0000_0100, "compare moved");
      wr(ADDR_RESP_MASK, 32'hFFFF_FFF7);
      rd(ADDR_RESP_MASK, 32'hFFFF_FFF7, "mask read");
      rv = 12'hFFF;
      tick(1);
      rv = 12'h000;
      chk(o_resp_msg, 32'h0000_0008, "masked msg");
      wr(ADDR_RESP_MASK, 32'hFFFF_FFFF);
      rv = 12'hFFF;
      tick(1);
      rv = 12'h000;
      chk({31'h0, o_resp_valid}, 32'h0000_0000, "all masked");
      tick(2);
      chk({24'h0, msg_cnt}, 32'h0000_0011, "message count");
      chk(last_msg, 32'h0000_0008, "last message");
      $display("test response done");
      give_verdict();
   end
endmodule : desl_top_test
`default_nettype wire
